// [design/epm_port.v]
`timescale 1ns/1ps
`include "epm_defines.vh"
// What this block does
// - Distributed arbitration for six processors plus host.
// - Mastership changeover costs one cycle.
// - Fixed or rotating priority selectable.
// - Lock holds mastership across read-modify-write.
// - Broadcast writes accepted by every slave processor.
// - 32-bit words on data bits 47-16.
// - 40-bit words on data bits 47-8.
// - 16-bit words on data bits 31-16.
// - Byte boot transfers on bits 23-16.
// - Bank selects decoded, inactive when idle.
// - Bank select asserted for false conditional access.
// - Page flag on bank 0 page crossing.
// - Read strobe low on reads, either direction.
// - Write strobe low on writes, either direction.
// - Only bus master drives strobes and selects.
// - Write select early with address, abortable.
// - Boot memory strap uses boot select output.
// - Link boot strap selects link boot.
// - Host boot or no boot from select input.
// - Boot select three-statable only in memory boot.
// - Outputs float as slave or on tristate request.
// - Both boot straps high is reserved.
module epm_port (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Configuration
  input wire [2:0] proc_id,
  input wire prio_mode,
  input wire [3:0] bank_size_field,
  input wire [2:0] page_size,
  // Core access request
  input wire acc_req,
  input wire acc_write,
  input wire acc_cond_true,
  input wire acc_lock,
  input wire acc_bcast,
  input wire [1:0] acc_size,
  input wire [31:0] acc_addr,
  input wire [47:0] acc_wdata,
  output wire acc_grant,
  output reg [47:0] acc_rdata_reg,
  output reg acc_done_reg,
  // Arbitration requests of peers and host
  input wire [6:0] peer_req,
  input wire bus_tristate_request,
  // External address and data bus
  input wire [31:0] ext_address_bus_i,
  output reg [31:0] ext_address_bus_o,
  output wire ext_address_bus_oe,
  input wire [47:0] ext_data_bus_i,
  output reg [47:0] ext_data_bus_o,
  output wire ext_data_bus_oe,
  // Strobes and selects
  input wire rd_n_i,
  output reg rd_n_o,
  output wire rd_n_oe,
  input wire wr_n_i,
  output reg wr_n_o,
  output wire wr_n_oe,
  input wire sync_write_select_n_i,
  output reg sync_write_select_n_o,
  output wire sync_write_select_n_oe,
  output reg [3:0] bank_select_n,
  output wire bank_select_oe,
  output reg page_flag,
  output wire page_flag_oe,
  output wire bus_clock_reference,
  output wire bus_clock_reference_oe,
  // Boot straps and boot select
  input wire boot_memory_strap,
  input wire link_boot_strap,
  input wire boot_chip_select_i,
  output reg boot_chip_select_o,
  output wire boot_chip_select_oe,
  output reg [3:0] boot_mode_reg,
  // Slave side: access by another master
  output reg slave_wr_reg,
  output reg slave_rd_reg,
  output reg [31:0] slave_addr_reg,
  output reg [47:0] slave_wdata_reg,
  input wire [47:0] slave_rdata
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [9:0] sy1_reg;
  reg [9:0] sy2_reg;
  wire [9:0] sy_in;
  assign sy_in = {peer_req[6], rd_n_i, wr_n_i, sync_write_select_n_i,
                  bus_tristate_request, boot_memory_strap,
                  link_boot_strap, boot_chip_select_i, 2'h0};
  always @(posedge sys_clk) begin
    if (srst) begin
      // Idle pin levels, so no false strobe edge follows reset.
      sy1_reg <= 10'h1c0;
      sy2_reg <= 10'h1c0;
    end else begin
      sy1_reg <= sy_in;
      sy2_reg <= sy1_reg;
    end
  end
  wire host_req_s = sy2_reg[9];
  wire rd_n_s = sy2_reg[8];
  wire wr_n_s = sy2_reg[7];
  wire sws_n_s = sy2_reg[6];
  wire tsr_s = sy2_reg[5];
  // ----------------------------------------
  // Boot strap capture
  // ----------------------------------------
  // Straps are taken after the synchronisers settle, not at reset itself.
  reg [1:0] rst_cnt_reg;
  always @(posedge sys_clk) begin
    if (srst) begin
      rst_cnt_reg <= 2'h0;
      boot_mode_reg <= `EPM_BOOT_RSVD;
    end else if (rst_cnt_reg != 2'h3) begin
      rst_cnt_reg <= rst_cnt_reg + 2'h1;
      if (rst_cnt_reg == 2'h2) begin
        if (sy2_reg[4] && sy2_reg[3]) begin
          boot_mode_reg <= `EPM_BOOT_RSVD;
        end else if (sy2_reg[4]) begin
          boot_mode_reg <= `EPM_BOOT_MEM;
        end else if (sy2_reg[3]) begin
          boot_mode_reg <= `EPM_BOOT_LINK;
        end else if (sy2_reg[2]) begin
          boot_mode_reg <= `EPM_BOOT_HOST;
        end else begin
          boot_mode_reg <= `EPM_BOOT_NONE;
        end
      end
    end
  end
  wire mem_boot = (boot_mode_reg == `EPM_BOOT_MEM);
  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  wire [6:0] req_vec;
  wire [6:0] grant;
  genvar g;
  generate
    for (g = 0; g < `EPM_NPROC; g = g + 1) begin : g_req
      assign req_vec[g] = (proc_id == g) ? acc_req : peer_req[g];
    end
  endgenerate
  assign req_vec[`EPM_HOST_IDX] = host_req_s;
  // Lock only counts while this processor holds the bus.
  wire arb_lock = acc_lock & grant[proc_id];
  epm_arbiter u_arb (
    .sys_clk(sys_clk),
    .srst(srst),
    .req(req_vec),
    .prio_mode(prio_mode),
    .lock(arb_lock),
    .grant_reg(grant)
  );
  wire is_master = grant[proc_id];
  assign acc_grant = is_master;
  // ----------------------------------------
  // Master access sequencer
  // ----------------------------------------
  localparam ST_IDLE = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_STRB = 3'h4;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [31:0] last_addr_reg;
  reg [1:0] size_reg;
  reg write_reg;
  reg cond_reg;
  wire [3:0] bank_dec;
  wire [31:0] bank_rel = acc_addr >> `EPM_BANK_BASE_BIT;
  // Bank index is address above base shifted by the configured size.
  wire [31:0] bank_idx = bank_rel >> bank_size_field;
  assign bank_dec = (bank_idx < 32'h4) ? (4'h1 << bank_idx[1:0]) : 4'h0;
  wire [31:0] page_mask = 32'hffffffff << (`EPM_PAGE_BASE_BIT + page_size);
  wire page_cross = ((acc_addr & page_mask) != (last_addr_reg & page_mask));
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // A request still up in the done cycle is the old one.
        if (acc_req && is_master && !acc_done_reg) begin
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        state_next = ST_STRB;
      end
      ST_STRB: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end
  // Data lane placement per word size.
  function [47:0] place;
    input [1:0] sz;
    input [47:0] d;
    begin
      case (sz)
        `EPM_WSZ_32: place = {d[31:0], 16'h0000};
        `EPM_WSZ_40: place = {d[39:0], 8'h00};
        `EPM_WSZ_16: place = {16'h0000, d[15:0], 16'h0000};
        `EPM_WSZ_8: place = {24'h000000, d[7:0], 16'h0000};
        default: place = 48'h0;
      endcase
    end
  endfunction
  function [47:0] extract;
    input [1:0] sz;
    input [47:0] d;
    begin
      case (sz)
        `EPM_WSZ_32: extract = {16'h0000, d[47:16]};
        `EPM_WSZ_40: extract = {8'h00, d[47:8]};
        `EPM_WSZ_16: extract = {32'h0, d[31:16]};
        `EPM_WSZ_8: extract = {40'h0, d[23:16]};
        default: extract = 48'h0;
      endcase
    end
  endfunction
  always @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      ext_address_bus_o <= 32'h0;
      ext_data_bus_o <= 48'h0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      sync_write_select_n_o <= 1'b1;
      bank_select_n <= 4'hf;
      page_flag <= 1'b0;
      boot_chip_select_o <= 1'b1;
      last_addr_reg <= 32'h0;
      size_reg <= `EPM_WSZ_32;
      write_reg <= 1'b0;
      cond_reg <= 1'b0;
      acc_rdata_reg <= 48'h0;
      acc_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      acc_done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          rd_n_o <= 1'b1;
          wr_n_o <= 1'b1;
          sync_write_select_n_o <= 1'b1;
          bank_select_n <= 4'hf;
          boot_chip_select_o <= 1'b1;
          page_flag <= 1'b0;
          if (state_next == ST_ADDR) begin
            ext_address_bus_o <= acc_addr;
            size_reg <= acc_size;
            write_reg <= acc_write;
            cond_reg <= acc_cond_true;
            ext_data_bus_o <= place(acc_size, acc_wdata);
            // Select moves with the address, condition ignored.
            if (mem_boot && acc_size == `EPM_WSZ_8) begin
              boot_chip_select_o <= 1'b0;
            end else begin
              bank_select_n <= ~bank_dec;
              // Byte boot fetches use the boot select, never bank 0.
              page_flag <= bank_dec[0] && page_cross;
            end
            sync_write_select_n_o <= ~acc_write;
            last_addr_reg <= acc_addr;
          end
        end
        ST_ADDR: begin
          if (cond_reg) begin
            rd_n_o <= write_reg;
            wr_n_o <= ~write_reg;
          end
        end
        ST_STRB: begin
          rd_n_o <= 1'b1;
          wr_n_o <= 1'b1;
          sync_write_select_n_o <= 1'b1;
          bank_select_n <= 4'hf;
          boot_chip_select_o <= 1'b1;
          page_flag <= 1'b0;
          acc_rdata_reg <= extract(size_reg, ext_data_bus_i);
          acc_done_reg <= 1'b1;
        end
        default: begin
          rd_n_o <= 1'b1;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Output enables
  // ----------------------------------------
  wire drive = is_master && !tsr_s;
  assign ext_address_bus_oe = drive;
  assign ext_data_bus_oe = drive && write_reg && (state_reg != ST_IDLE);
  assign rd_n_oe = drive;
  assign wr_n_oe = drive;
  assign sync_write_select_n_oe = drive;
  assign bank_select_oe = drive;
  assign page_flag_oe = drive;
  assign bus_clock_reference = sys_clk;
  assign bus_clock_reference_oe = drive;
  assign boot_chip_select_oe = drive && mem_boot;
  // ----------------------------------------
  // Slave side
  // ----------------------------------------
  // A write with the write select high is ignored; a read needs the write select high.
  reg wr_n_d_reg;
  wire sl_addr_hit = (ext_address_bus_i[31:`EPM_EXT_SPACE_BIT] == 10'h0);
  always @(posedge sys_clk) begin
    if (srst) begin
      wr_n_d_reg <= 1'b1;
      slave_wr_reg <= 1'b0;
      slave_rd_reg <= 1'b0;
      slave_addr_reg <= 32'h0;
      slave_wdata_reg <= 48'h0;
    end else begin
      wr_n_d_reg <= wr_n_s;
      slave_wr_reg <= 1'b0;
      slave_rd_reg <= 1'b0;
      if (!is_master && sl_addr_hit) begin
        // Broadcast writes land here in every slave processor at once.
        if (!wr_n_s && wr_n_d_reg && !sws_n_s) begin
          slave_wr_reg <= 1'b1;
          slave_addr_reg <= ext_address_bus_i;
          slave_wdata_reg <= ext_data_bus_i;
        end
        if (!rd_n_s && sws_n_s) begin
          slave_rd_reg <= 1'b1;
          slave_addr_reg <= ext_address_bus_i;
        end
      end
    end
  end
  wire [47:0] unused_rd = slave_rdata;
endmodule // epm_port

// [design/epm_defines.vh]
`ifndef EPM_DEFINES_VH
`define EPM_DEFINES_VH
// ----------------------------------------
// Processor identities and arbitration
// ----------------------------------------
`define EPM_NPROC 6
`define EPM_HOST_IDX 6
`define EPM_NREQ 7
`define EPM_PRIO_FIXED 1'b0
`define EPM_PRIO_ROT 1'b1
// ----------------------------------------
// Word sizes on the data bus
// ----------------------------------------
`define EPM_WSZ_32 2'h0
`define EPM_WSZ_40 2'h1
`define EPM_WSZ_16 2'h2
`define EPM_WSZ_8 2'h3
// ----------------------------------------
// Boot modes, one-hot; reserved is all zero
// ----------------------------------------
`define EPM_BOOT_NONE 4'h1
`define EPM_BOOT_HOST 4'h2
`define EPM_BOOT_LINK 4'h4
`define EPM_BOOT_MEM 4'h8
`define EPM_BOOT_RSVD 4'h0
// ----------------------------------------
// Bank decode
// ----------------------------------------
`define EPM_BANK_BASE_BIT 12
`define EPM_BANK_SIZE_W 4
`define EPM_PAGE_SIZE_W 3
`define EPM_PAGE_BASE_BIT 8
`define EPM_EXT_SPACE_BIT 22
`endif

// [design/epm_arbiter.v]
`timescale 1ns/1ps
module epm_arbiter (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Requests and control
  input wire [6:0] req,
  input wire prio_mode,
  input wire lock,
  // Grant
  output reg [6:0] grant_reg
);
  // ----------------------------------------
  // Grant selection
  // ----------------------------------------
  reg [2:0] last_reg;
  reg [6:0] grant_next;
  reg [2:0] idx;
  reg found;
  reg [3:0] sum;
  integer i;
  integer j;
  always @* begin
    grant_next = 7'h00;
    found = 1'b0;
    idx = 3'h0;
    sum = 4'h0;
    if (lock) begin
      grant_next = grant_reg;
    end else if (|(grant_reg & req)) begin
      // The master keeps the bus until it lets its request go.
      grant_next = grant_reg;
    end else if (req[`EPM_HOST_IDX]) begin
      grant_next = 7'h40;
    end else begin
      for (i = 0; i < `EPM_NPROC; i = i + 1) begin
        if (prio_mode == `EPM_PRIO_ROT) begin
          sum = {1'b0, last_reg} + 4'h1 + {1'b0, i[2:0]};
          idx = (sum >= 4'h6) ? sum[2:0] - 3'h6 : sum[2:0];
        end else begin
          idx = i[2:0];
        end
        if (!found && req[idx]) begin
          found = 1'b1;
          grant_next = 7'h01 << idx;
        end
      end
    end
  end
  // Grant moves in one edge, so changeover costs a single cycle.
  always @(posedge sys_clk) begin
    if (srst) begin
      grant_reg <= 7'h00;
      last_reg <= 3'h5;
    end else begin
      grant_reg <= grant_next;
      for (j = 0; j < `EPM_NPROC; j = j + 1) begin
        if (grant_next[j]) begin
          last_reg <= j[2:0];
        end
      end
    end
  end
endmodule // epm_arbiter

// [tb/epm_port_props.sv]
`timescale 1ns/1ps
`include "epm_defines.vh"
module epm_port_checker (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Core side
  input wire acc_req,
  input wire acc_grant,
  input wire acc_cond_true,
  input wire acc_done_reg,
  input wire bus_tristate_request,
  // Bus side
  input wire ext_address_bus_oe,
  input wire rd_n_o,
  input wire rd_n_oe,
  input wire wr_n_o,
  input wire wr_n_oe,
  input wire sync_write_select_n_o,
  input wire [3:0] bank_select_n,
  input wire page_flag,
  // Boot
  input wire boot_chip_select_oe,
  input wire [3:0] boot_mode_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ----
  // Transfer shape
  // ----
  property p_rd_pulse;
    $fell(rd_n_o) |=> rd_n_o && acc_done_reg;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read strobe not one cycle before completion");
  property p_wr_pulse;
    $fell(wr_n_o) |=> wr_n_o && acc_done_reg;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe not one cycle before completion");
  property p_wr_early;
    !wr_n_o |-> !sync_write_select_n_o && !$past(sync_write_select_n_o);
  endproperty
  a_wr_early: assert property (p_wr_early)
    else $error("write strobe without earlier write select");
  property p_rd_sw;
    !rd_n_o |-> sync_write_select_n_o;
  endproperty
  a_rd_sw: assert property (p_rd_sw)
    else $error("write select low during a read");
  property p_sel_idle;
    bank_select_n != 4'hf |-> acc_req || $past(acc_req);
  endproperty
  a_sel_idle: assert property (p_sel_idle)
    else $error("bank select active with no access");
  property p_cond_false;
    acc_req && !acc_cond_true |-> rd_n_o && wr_n_o;
  endproperty
  a_cond_false: assert property (p_cond_false)
    else $error("strobe on a false conditional access");
  property p_page_bank0;
    page_flag |-> bank_select_n == 4'he;
  endproperty
  a_page_bank0: assert property (p_page_bank0)
    else $error("page flag outside bank 0");
  // ----
  // Ownership and boot
  // ----
  property p_tristate;
    bus_tristate_request [*4] |-> !ext_address_bus_oe && !rd_n_oe && !wr_n_oe;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("bus driven during three-state request");
  property p_oe_group;
    rd_n_oe |-> acc_grant && wr_n_oe && ext_address_bus_oe;
  endproperty
  a_oe_group: assert property (p_oe_group)
    else $error("master outputs not enabled together");
  property p_boot_oe;
    boot_chip_select_oe |-> boot_mode_reg == `EPM_BOOT_MEM;
  endproperty
  a_boot_oe: assert property (p_boot_oe)
    else $error("boot select driven outside memory boot");
  property p_boot_hold;
    (!srst) [*5] |=> $stable(boot_mode_reg);
  endproperty
  a_boot_hold: assert property (p_boot_hold)
    else $error("boot mode changed without reset");
endmodule // epm_port_checker
bind epm_port epm_port_checker i_epm_port_checker (.sys_clk, .srst,
  .acc_req, .acc_grant, .acc_cond_true, .acc_done_reg, .bus_tristate_request,
  .ext_address_bus_oe, .rd_n_o, .rd_n_oe, .wr_n_o, .wr_n_oe,
  .sync_write_select_n_o, .bank_select_n, .page_flag,
  .boot_chip_select_oe, .boot_mode_reg);

// [tb/epm_mem_model.sv]
`timescale 1ns/1ps
module epm_mem_model (
  // Clock
  input wire sys_clk,
  // Board wires
  input wire [31:0] addr,
  input wire [47:0] wdata,
  input wire rd_n,
  input wire wr_n,
  input wire [3:0] bank_select_n,
  input wire boot_sel_n,
  // Read data
  output reg [47:0] rdata
);
  reg [47:0] mem [0:15];
  reg [47:0] last = 48'h0;
  wire sel = (bank_select_n != 4'hf) || !boot_sel_n;
  integer i;
  initial begin
    for (i = 0; i < 16; i++) mem[i] = 48'h5a5a00000000 ^ i;
  end
  // A released bus toggles every cycle so stale data never passes.
  always @* begin
    if (!rd_n && sel) rdata = mem[addr[3:0]];
    else rdata = ~last;
  end
  always @(posedge sys_clk) begin
    last <= rdata;
    if (!wr_n && sel) mem[addr[3:0]] <= wdata;
  end
endmodule // epm_mem_model

// [tb/epm_port_bench.sv]
`timescale 1ns/1ps
`include "epm_defines.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module epm_port_bench;
  // ----
  // Stimulus, wires
  // ----
  reg sys_clk = 0, srst = 1, prio_mode = 0, acc_req = 0, acc_write = 0;
  reg acc_cond_true = 0, acc_lock = 0, bus_tristate_request = 0, slv = 0;
  reg boot_memory_strap = 0, link_boot_strap = 0, b_rd = 1, b_wr = 1;
  reg b_sw = 1, b_bcs = 0, st, pf, sc, pv = 0;
  reg [1:0] acc_size = 0, s;
  reg [2:0] page_size = 0;
  reg [3:0] bank_size_field = 0, sb;
  reg [6:0] peer_req = 0;
  reg [31:0] acc_addr = 0, b_addr = 0, a, ppg;
  reg [47:0] acc_wdata = 0, b_dat = 0, d, sd;
  integer i, k, mismatches = 0, n_checks = 0, cyc = 0;
  wire acc_grant, acc_done_reg, ext_address_bus_oe, ext_data_bus_oe;
  wire rd_n_o, rd_n_oe, wr_n_o, wr_n_oe, page_flag, slave_wr_reg;
  wire sync_write_select_n_o, sync_write_select_n_oe, slave_rd_reg;
  wire boot_chip_select_o, boot_chip_select_oe;
  wire [3:0] bank_select_n, boot_mode_reg;
  wire [31:0] ext_address_bus_o, slave_addr_reg;
  wire [47:0] acc_rdata_reg, ext_data_bus_o, slave_wdata_reg, m_dat;
  wire [31:0] a_w = ext_address_bus_oe ? ext_address_bus_o : b_addr;
  wire [47:0] d_w = ext_data_bus_oe ? ext_data_bus_o : slv ? b_dat : m_dat;
  wire rd_w = rd_n_oe ? rd_n_o : b_rd;
  wire wr_w = wr_n_oe ? wr_n_o : b_wr;
  wire sw_w = sync_write_select_n_oe ? sync_write_select_n_o : b_sw;
  wire bcs_w = boot_chip_select_oe ? boot_chip_select_o :
    boot_memory_strap ? 1'b1 : b_bcs;
  always #20 sys_clk = ~sys_clk;
  epm_port i_epm_port (.sys_clk, .srst, .proc_id(3'h0), .prio_mode,
    .bank_size_field, .page_size, .acc_req, .acc_write, .acc_cond_true,
    .acc_lock, .acc_bcast(1'b0), .acc_size, .acc_addr, .acc_wdata,
    .acc_grant, .acc_rdata_reg, .acc_done_reg, .peer_req,
    .bus_tristate_request, .ext_address_bus_i(a_w), .ext_address_bus_o,
    .ext_address_bus_oe, .ext_data_bus_i(d_w), .ext_data_bus_o,
    .ext_data_bus_oe, .rd_n_i(rd_w), .rd_n_o, .rd_n_oe, .wr_n_i(wr_w),
    .wr_n_o, .wr_n_oe, .sync_write_select_n_i(sw_w), .sync_write_select_n_o,
    .sync_write_select_n_oe, .bank_select_n, .bank_select_oe(), .page_flag,
    .page_flag_oe(), .bus_clock_reference(), .bus_clock_reference_oe(),
    .boot_memory_strap, .link_boot_strap, .boot_chip_select_i(bcs_w),
    .boot_chip_select_o, .boot_chip_select_oe, .boot_mode_reg, .slave_wr_reg,
    .slave_rd_reg, .slave_addr_reg, .slave_wdata_reg, .slave_rdata(48'h0));
  epm_mem_model i_epm_mem_model (.sys_clk, .addr(a_w), .wdata(d_w),
    .rd_n(rd_w), .wr_n(wr_w), .bank_select_n, .boot_sel_n(bcs_w),
    .rdata(m_dat));
  // ----
  // Expectations
  // ----
  function [47:0] lane(input [1:0] z, input [47:0] v);
    lane = z == 0 ? {v[31:0], 16'h0} : z == 1 ? {v[39:0], 8'h0} :
      z == 2 ? {16'h0, v[15:0], 16'h0} : {24'h0, v[7:0], 16'h0};
  endfunction
  function [47:0] rj(input [1:0] z, input [47:0] v);
    rj = z == 0 ? {16'h0, v[31:0]} : z == 1 ? {8'h0, v[39:0]} :
      z == 2 ? {32'h0, v[15:0]} : {40'h0, v[7:0]};
  endfunction
  function [3:0] bsel(input [31:0] x);
    bsel = ((x >> 12) >> bank_size_field) < 4 ?
      ~(4'h1 << ((x >> 12) >> bank_size_field)) : 4'hf;
  endfunction
  function [3:0] bmode(input [2:0] t);
    bmode = t[2] ? (t[1] ? `EPM_BOOT_RSVD : `EPM_BOOT_MEM) : t[1] ?
      `EPM_BOOT_LINK : t[0] ? `EPM_BOOT_HOST : `EPM_BOOT_NONE;
  endfunction
  // ----
  // Tasks
  // ----
  task test_done;
    begin
      if (mismatches == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task rst(input [2:0] t);
    begin
      @(posedge sys_clk);
      srst <= 1;
      boot_memory_strap <= t[2];
      link_boot_strap <= t[1];
      b_bcs <= t[0];
      repeat (2) @(posedge sys_clk);
      srst <= 0;
    end
  endtask
  // Request stands until the edge at which done is sampled high.
  task acc(input w, input c, input [1:0] z, input [31:0] x, input [47:0] v);
    begin
      sb = 4'hf; st = 0; sc = 1; pf = 0; sd = 0;
      @(posedge sys_clk);
      acc_req <= 1; acc_write <= w; acc_cond_true <= c;
      acc_size <= z; acc_addr <= x; acc_wdata <= v;
      for (k = 0; k < 40; k++) begin
        @(negedge sys_clk);
        if (bank_select_n != 4'hf) sb = bank_select_n;
        if (boot_chip_select_oe && !boot_chip_select_o) sc = 0;
        if (!rd_n_o || !wr_n_o) begin
          st = 1; sd = ext_data_bus_o; pf = page_flag;
        end
        if (acc_done_reg === 1'b1) break;
      end
      `CHK(acc_done_reg, 1'b1)
      @(posedge sys_clk);
      acc_req <= 0;
    end
  endtask
  task chk(input [31:0] x, input [1:0] z, input [47:0] v);
    begin
      `CHK(sb, bsel(x))
      `CHK(st, 1'b1)
      if (acc_write) `CHK(sd & lane(z, ~48'h0), lane(z, v))
      if (bsel(x) != 4'he) `CHK(pf, 1'b0)
      else if (pv) `CHK(pf, (x >> (8 + page_size)) != ppg)
      pv = bsel(x) == 4'he;
      ppg = x >> (8 + page_size);
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches = mismatches + 1;
      test_done;
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(79));
    rst(3'b000);
    page_size <= 3'($urandom % 8);
    for (i = 0; i < 12; i++) begin
      s = 2'(i % 3);
      @(posedge sys_clk);
      bank_size_field <= 4'($urandom % 4);
      @(posedge sys_clk);
      a = $urandom % (32'h5000 << bank_size_field);
      if (i == 11) a = (32'h4000 << bank_size_field) - 1;
      d = {16'($urandom), $urandom};
      acc(1, 1, s, a, d);
      chk(a, s, d);
      acc(0, 1, s, a, d);
      chk(a, s, d);
      if (bsel(a) != 4'hf) `CHK(acc_rdata_reg, rj(s, d))
    end
    acc(1, 0, 2'h0, 32'h0, 48'h0);
    `CHK(sb, 4'he)
    `CHK(st, 1'b0)
    for (i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      prio_mode <= i[0];
      peer_req <= i ? 7'h02 : 7'h40;
      repeat (3) @(posedge sys_clk);
      fork
        acc(0, 1, 2'h0, 32'h0, 48'h0);
        begin
          repeat (3) @(negedge sys_clk);
          `CHK(acc_grant, 1'b0)
          @(posedge sys_clk);
          peer_req <= 7'h0;
          repeat (i ? 1 : 3) @(negedge sys_clk);
          `CHK(acc_grant, 1'b0)
          @(negedge sys_clk);
          `CHK(acc_grant, 1'b1)
        end
      join
    end
    @(posedge sys_clk);
    acc_lock <= 1;
    acc(1, 1, 2'h0, 32'h4, 48'h0);
    bus_tristate_request <= 1;
    repeat (5) @(negedge sys_clk);
    `CHK(ext_address_bus_oe, 1'b0)
    @(posedge sys_clk);
    bus_tristate_request <= 0;
    peer_req <= 7'h02;
    repeat (3) @(negedge sys_clk);
    `CHK(acc_grant, 1'b1)
    acc(0, 1, 2'h0, 32'h4, 48'h0);
    acc_lock <= 0;
    repeat (4) @(negedge sys_clk);
    `CHK(rd_n_oe, 1'b0)
    a = $urandom % 32'h400000;
    d = {16'($urandom), $urandom};
    @(posedge sys_clk);
    slv <= 1; b_addr <= a; b_dat <= d; b_sw <= 0;
    @(posedge sys_clk);
    b_wr <= 0;
    @(posedge sys_clk);
    b_wr <= 1;
    for (k = 0; k < 10 && slave_wr_reg !== 1'b1; k++) @(negedge sys_clk);
    `CHK(slave_wr_reg, 1'b1)
    `CHK({slave_addr_reg, slave_wdata_reg}, {a, d})
    @(posedge sys_clk);
    b_sw <= 1; b_rd <= 0;
    for (k = 0; k < 10 && slave_rd_reg !== 1'b1; k++) @(negedge sys_clk);
    `CHK(slave_rd_reg, 1'b1)
    @(posedge sys_clk);
    b_rd <= 1; slv <= 0; peer_req <= 0;
    for (i = 0; i < 8; i++) begin
      rst(i[2:0]);
      repeat (5) @(negedge sys_clk);
      `CHK(boot_mode_reg, bmode(i[2:0]))
      @(posedge sys_clk);
      b_bcs <= ~b_bcs; link_boot_strap <= ~link_boot_strap;
      boot_memory_strap <= ~boot_memory_strap;
      repeat (5) @(negedge sys_clk);
      `CHK(boot_mode_reg, bmode(i[2:0]))
    end
    rst(3'b100);
    repeat (5) @(posedge sys_clk);
    acc(1, 1, 2'h3, 32'h5, d);
    `CHK({sc, sb}, {1'b0, 4'hf})
    `CHK(sd & lane(2'h3, ~48'h0), lane(2'h3, d))
    acc(0, 1, 2'h3, 32'h5, d);
    `CHK(acc_rdata_reg, rj(2'h3, d))
    test_done;
  end
endmodule // epm_port_bench
